/* File: rtl/ieb_bank.sv */
// Per-port internal error control and status bank with interrupt layer.
// Assumes synchronous event pulses and a simple one-cycle register port.
//
// Functional notes
// [RULE1] Control bit 0 resets to one; while set, errors go to error reporting.
// [RULE2] Ingress buffer posted, non-posted, completion time-outs set bits 0, 1, 2.
// [RULE3] Egress buffer posted, non-posted, completion time-outs set bits 4, 5, 6.
// [RULE4] Ingress data RAM: corrected single error bit 7, double error bit 8.
// [RULE5] Ingress control RAM: corrected single error bit 9, double bit 10.
// [RULE6] Egress data RAM: corrected single error bit 11, double bit 12.
// [RULE7] Egress control RAM: corrected single error bit 13, double bit 14.
// [RULE8] Data path parity error of normal traffic sets bit 15.
// [RULE9] Replay control RAM: corrected single error bit 17, double bit 18.
// [RULE10] DMA ingress posted, non-posted, completion time-outs set bits 19-21.
// [RULE11] DMA ingress data RAM: single error bit 23, double bit 24.
// [RULE12] DMA ingress control RAM: single error bit 25, double bit 26.
// [RULE13] DMA egress RAM: single error bit 27, double bit 28.
// [RULE14] DMA data path parity error sets bit 31.
// [RULE15] Without DMA function every DMA status bit stays zero.
// [RULE16] Write one clears a flag; flags and enable survive warm reset. The interrupt flags and interrupt enable here clear on warm reset.
// [RULE17] Reserved bits read zero and ignore writes.
//
// The strobed register port is this design's own decision.
`default_nettype none

module ieb_bank #(
  parameter bit HAS_DMA = 1'b1
) (
  // Clock, resets, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        rst_warm_n,
  input  wire logic        ce,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_q,
  // Frame buffer time-outs
  input  wire logic        ingress_posted_timeout,
  input  wire logic        ingress_nonposted_timeout,
  input  wire logic        ingress_completion_timeout,
  input  wire logic        egress_posted_timeout,
  input  wire logic        egress_nonposted_timeout,
  input  wire logic        egress_completion_timeout,
  // RAM ECC and parity events
  input  wire logic        ingress_data_single_err,
  input  wire logic        ingress_data_double_err,
  input  wire logic        ingress_ctl_single_err,
  input  wire logic        ingress_ctl_double_err,
  input  wire logic        egress_data_single_err,
  input  wire logic        egress_data_double_err,
  input  wire logic        egress_ctl_single_err,
  input  wire logic        egress_ctl_double_err,
  input  wire logic        datapath_parity_err,
  input  wire logic        replay_ctl_single_err,
  input  wire logic        replay_ctl_double_err,
  // DMA function events
  input  wire logic        dma_in_posted_timeout,
  input  wire logic        dma_in_nonposted_timeout,
  input  wire logic        dma_in_completion_timeout,
  input  wire logic        dma_in_data_single_err,
  input  wire logic        dma_in_data_double_err,
  input  wire logic        dma_in_ctl_single_err,
  input  wire logic        dma_in_ctl_double_err,
  input  wire logic        dma_out_single_err,
  input  wire logic        dma_out_double_err,
  input  wire logic        dma_datapath_parity_err,
  // Reporting and interrupt
  output logic             aer_corr_q,
  output logic             aer_uncorr_q,
  output logic             irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic        int_err_report_enable_q;
  logic [31:0] irq_en_q;
  logic [31:0] ev_raw;
  logic [31:0] ev;
  logic [31:0] dma_keep;
  logic [31:0] rd_mux;
  logic        warm_rst_n;
  logic        wr_ctrl;
  logic        wr_sts;
  logic        wr_irq_en;
  logic        wr_irq_clr;

  ieb_flag_if #(.W(32)) sts_if ();
  ieb_flag_if #(.W(32)) irq_if ();

  // ****************************************************************
  // Event collection
  // ****************************************************************

  // Place each detection pulse at its status position
  always_comb begin
    ev_raw = 32'h0000_0000;
    ev_raw[ieb_pkg::B_IN_P_TO]    = ingress_posted_timeout;     // RULE2
    ev_raw[ieb_pkg::B_IN_NP_TO]   = ingress_nonposted_timeout;  // RULE2
    ev_raw[ieb_pkg::B_IN_CPL_TO]  = ingress_completion_timeout; // RULE2
    ev_raw[ieb_pkg::B_EG_P_TO]    = egress_posted_timeout;      // RULE3
    ev_raw[ieb_pkg::B_EG_NP_TO]   = egress_nonposted_timeout;   // RULE3
    ev_raw[ieb_pkg::B_EG_CPL_TO]  = egress_completion_timeout;  // RULE3
    ev_raw[ieb_pkg::B_IN_DAT_SBE] = ingress_data_single_err;    // RULE4
    ev_raw[ieb_pkg::B_IN_DAT_DBE] = ingress_data_double_err;    // RULE4
    ev_raw[ieb_pkg::B_IN_CTL_SBE] = ingress_ctl_single_err;     // RULE5
    ev_raw[ieb_pkg::B_IN_CTL_DBE] = ingress_ctl_double_err;     // RULE5
    ev_raw[ieb_pkg::B_EG_DAT_SBE] = egress_data_single_err;     // RULE6
    ev_raw[ieb_pkg::B_EG_DAT_DBE] = egress_data_double_err;     // RULE6
    ev_raw[ieb_pkg::B_EG_CTL_SBE] = egress_ctl_single_err;      // RULE7
    ev_raw[ieb_pkg::B_EG_CTL_DBE] = egress_ctl_double_err;      // RULE7
    ev_raw[ieb_pkg::B_PARITY]     = datapath_parity_err;        // RULE8
    ev_raw[ieb_pkg::B_RP_CTL_SBE] = replay_ctl_single_err;      // RULE9
    ev_raw[ieb_pkg::B_RP_CTL_DBE] = replay_ctl_double_err;      // RULE9
    ev_raw[ieb_pkg::B_DI_P_TO]    = dma_in_posted_timeout;      // RULE10
    ev_raw[ieb_pkg::B_DI_NP_TO]   = dma_in_nonposted_timeout;   // RULE10
    ev_raw[ieb_pkg::B_DI_CPL_TO]  = dma_in_completion_timeout;  // RULE10
    ev_raw[ieb_pkg::B_DI_DAT_SBE] = dma_in_data_single_err;     // RULE11
    ev_raw[ieb_pkg::B_DI_DAT_DBE] = dma_in_data_double_err;     // RULE11
    ev_raw[ieb_pkg::B_DI_CTL_SBE] = dma_in_ctl_single_err;      // RULE12
    ev_raw[ieb_pkg::B_DI_CTL_DBE] = dma_in_ctl_double_err;      // RULE12
    ev_raw[ieb_pkg::B_DO_SBE]     = dma_out_single_err;         // RULE13
    ev_raw[ieb_pkg::B_DO_DBE]     = dma_out_double_err;         // RULE13
    ev_raw[ieb_pkg::B_DMA_PARITY] = dma_datapath_parity_err;    // RULE14
  end

  // Drop DMA events on ports without DMA, and reserved positions
  assign dma_keep = HAS_DMA ? 32'hffff_ffff : ~ieb_pkg::STS_DMA_MASK; // RULE15
  assign ev       = ev_raw & dma_keep & ieb_pkg::STS_IMPL_MASK;      // RULE17

  // ****************************************************************
  // Register decode
  // ****************************************************************

  // Write strobes per register
  assign wr_ctrl    = reg_wr && (reg_addr == ieb_pkg::OFF_CTRL);
  assign wr_sts     = reg_wr && (reg_addr == ieb_pkg::OFF_STS_LOW);
  assign wr_irq_en  = reg_wr && (reg_addr == ieb_pkg::OFF_IRQ_ENABLE);
  assign wr_irq_clr = reg_wr && (reg_addr == ieb_pkg::OFF_IRQ_CLEAR);
  assign warm_rst_n = rst_n & rst_warm_n;

  // Enable bit: only a fundamental reset restores it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_err_report_enable_q <= ieb_pkg::CTRL_EN_RST; // RULE1 RULE16
    end else if (ce && wr_ctrl) begin
      int_err_report_enable_q <= reg_wdata[ieb_pkg::CTRL_EN_BIT]; // RULE17
    end
  end

  // Interrupt enable, cleared by any reset
  always_ff @(posedge clk) begin
    if (!warm_rst_n) begin
      irq_en_q <= ieb_pkg::IRQ_EN_RST;
    end else if (ce && wr_irq_en) begin
      irq_en_q <= reg_wdata & ieb_pkg::STS_IMPL_MASK;
    end
  end

  // ****************************************************************
  // Flag banks
  // ****************************************************************

  // Status flags: set by events, cleared by writing ones
  assign sts_if.set = ev;                                             // RULE2
  assign sts_if.clr = wr_sts ? reg_wdata : 32'h0000_0000;             // RULE16

  ieb_sticky_bank #(.W(32)) u_sts (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .fl    (sts_if.bank)
  );

  // Interrupt flags: same layout, cleared through the clear register
  assign irq_if.set = ev;
  assign irq_if.clr = wr_irq_clr ? reg_wdata : 32'h0000_0000;

  ieb_sticky_bank #(.W(32)) u_irq (
    .clk   (clk),
    .rst_n (warm_rst_n),
    .ce    (ce),
    .fl    (irq_if.bank)
  );

  assign irq = |(irq_if.flags & irq_en_q);

  // ****************************************************************
  // Error reporting
  // ****************************************************************
  ieb_aer_fwd u_fwd (
    .clk          (clk),
    .rst_n        (warm_rst_n),
    .ce           (ce),
    .report_en    (int_err_report_enable_q), // RULE1
    .ev           (ev),
    .aer_corr_q   (aer_corr_q),
    .aer_uncorr_q (aer_uncorr_q)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Select read value; unmapped and write-only read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      ieb_pkg::OFF_CTRL:       rd_mux = {31'h0, int_err_report_enable_q}; // RULE17
      ieb_pkg::OFF_STS_LOW:    rd_mux = sts_if.flags;
      ieb_pkg::OFF_IRQ_STATUS: rd_mux = irq_if.flags;
      ieb_pkg::OFF_IRQ_ENABLE: rd_mux = irq_en_q;
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!warm_rst_n) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_en_after_reset: assert property ( // RULE1
    !$past(rst_n) |-> int_err_report_enable_q == 1'h1)
    else $error("enable not one after reset");

  a_enable_write: assert property ( // RULE1
    (ce && wr_ctrl) |=> int_err_report_enable_q == $past(reg_wdata[ieb_pkg::CTRL_EN_BIT]))
    else $error("enable bit not written");

  a_report_gated: assert property ( // RULE1
    (ce && warm_rst_n && !int_err_report_enable_q) |=> !aer_corr_q && !aer_uncorr_q)
    else $error("error forwarded while disabled");

  a_report_uncorr: assert property ( // RULE1
    (ce && warm_rst_n && int_err_report_enable_q && ingress_data_double_err)
      |=> aer_uncorr_q)
    else $error("uncorrected error not forwarded");

  a_report_corr: assert property ( // RULE1
    (ce && warm_rst_n && int_err_report_enable_q && replay_ctl_single_err)
      |=> aer_corr_q)
    else $error("corrected error not forwarded");

  a_ingress_timeout: assert property ( // RULE2
    (ce && ingress_nonposted_timeout) |=> sts_if.flags[1])
    else $error("ingress time-out flag not set");

  a_egress_timeout: assert property ( // RULE3
    (ce && egress_completion_timeout) |=> sts_if.flags[6])
    else $error("egress time-out flag not set");

  a_in_data_ecc: assert property ( // RULE4
    (ce && ingress_data_single_err) |=> sts_if.flags[7])
    else $error("ingress data ecc flag not set");

  a_in_ctl_ecc: assert property ( // RULE5
    (ce && ingress_ctl_double_err) |=> sts_if.flags[10])
    else $error("ingress control ecc flag not set");

  a_eg_data_ecc: assert property ( // RULE6
    (ce && egress_data_double_err) |=> sts_if.flags[12])
    else $error("egress data ecc flag not set");

  a_eg_ctl_ecc: assert property ( // RULE7
    (ce && egress_ctl_single_err) |=> sts_if.flags[13])
    else $error("egress control ecc flag not set");

  a_parity_flag: assert property ( // RULE8
    (ce && datapath_parity_err) |=> sts_if.flags[15] ##1 (sts_if.flags[15] || $past(wr_sts)))
    else $error("parity flag not set or lost");

  a_replay_ecc: assert property ( // RULE9
    (ce && replay_ctl_double_err) |=> sts_if.flags[18])
    else $error("replay ecc flag not set");

  a_dma_timeout: assert property ( // RULE10
    (ce && HAS_DMA && dma_in_completion_timeout) |=> sts_if.flags[21])
    else $error("dma time-out flag not set");

  a_dma_in_data: assert property ( // RULE11
    (ce && HAS_DMA && dma_in_data_double_err) |=> sts_if.flags[24])
    else $error("dma data ecc flag not set");

  a_dma_in_ctl: assert property ( // RULE12
    (ce && HAS_DMA && dma_in_ctl_single_err) |=> sts_if.flags[25])
    else $error("dma control ecc flag not set");

  a_dma_out_ecc: assert property ( // RULE13
    (ce && HAS_DMA && dma_out_double_err) |=> sts_if.flags[28])
    else $error("dma egress ecc flag not set");

  a_dma_parity: assert property ( // RULE14
    (ce && HAS_DMA && dma_datapath_parity_err) |=> sts_if.flags[31])
    else $error("dma parity flag not set");

  a_dma_tied_zero: assert property ( // RULE15
    !HAS_DMA |-> (sts_if.flags & ieb_pkg::STS_DMA_MASK) == 32'h0000_0000)
    else $error("dma flag set on port without dma");

  a_w1c_clears: assert property ( // RULE16
    (ce && wr_sts) |=> (sts_if.flags & $past(reg_wdata) & ~$past(ev)) == 32'h0000_0000)
    else $error("write one did not clear flag");

  a_w0_keeps: assert property ( // RULE16
    (ce && wr_sts) |=> ($past(sts_if.flags) & ~$past(reg_wdata) & ~sts_if.flags) == 32'h0)
    else $error("write zero changed a flag");

  a_warm_keeps: assert property ( // RULE16
    (!rst_warm_n) |=> sts_if.flags == $past(sts_if.flags)
      || (sts_if.flags & ~$past(sts_if.flags)) != 32'h0)
    else $error("warm reset cleared sticky flag");

  a_reserved_zero: assert property ( // RULE17
    (sts_if.flags & ~ieb_pkg::STS_IMPL_MASK) == 32'h0000_0000)
    else $error("reserved status bit set");

  a_ctrl_read: assert property ( // RULE17
    (ce && warm_rst_n && reg_rd && reg_addr == ieb_pkg::OFF_CTRL)
      |=> reg_rdata_q == {31'h0, int_err_report_enable_q})
    else $error("control readback wrong");

  a_sts_readback: assert property ( // RULE16
    (ce && warm_rst_n && reg_rd && reg_addr == ieb_pkg::OFF_STS_LOW)
      |=> reg_rdata_q == $past(sts_if.flags))
    else $error("status readback wrong");

  c_flag_then_clear: cover property (
    sts_if.flags[0] ##1 (ce && wr_sts && reg_wdata[0]) ##1 !sts_if.flags[0]);
  c_set_wins_clear: cover property (ce && wr_sts && reg_wdata[8] && ingress_data_double_err);
  c_irq_raised: cover property (!irq ##1 irq);
  c_report_off: cover property (ce && wr_ctrl && !reg_wdata[0]);

endmodule : ieb_bank

`default_nettype wire

/* File: rtl/ieb_pkg.sv */
// Constants for the internal error status bank: map, fields, reset values.
// Assumes a 32-bit register port with byte addresses.
`default_nettype none

package ieb_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam logic [11:0] OFF_CTRL       = 12'h480;
  localparam logic [11:0] OFF_STS_LOW    = 12'h484;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h490;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h494;
  localparam logic [11:0] OFF_IRQ_CLEAR  = 12'h498;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        CTRL_EN_RST = 1'h1;
  localparam logic [31:0] STS_RST     = 32'h0000_0000;
  localparam logic [31:0] IRQ_EN_RST  = 32'h0000_0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_EN_BIT   = 0;
  localparam int B_IN_P_TO     = 0;
  localparam int B_IN_NP_TO    = 1;
  localparam int B_IN_CPL_TO   = 2;
  localparam int B_EG_P_TO     = 4;
  localparam int B_EG_NP_TO    = 5;
  localparam int B_EG_CPL_TO   = 6;
  localparam int B_IN_DAT_SBE  = 7;
  localparam int B_IN_DAT_DBE  = 8;
  localparam int B_IN_CTL_SBE  = 9;
  localparam int B_IN_CTL_DBE  = 10;
  localparam int B_EG_DAT_SBE  = 11;
  localparam int B_EG_DAT_DBE  = 12;
  localparam int B_EG_CTL_SBE  = 13;
  localparam int B_EG_CTL_DBE  = 14;
  localparam int B_PARITY      = 15;
  localparam int B_RP_CTL_SBE  = 17;
  localparam int B_RP_CTL_DBE  = 18;
  localparam int B_DI_P_TO     = 19;
  localparam int B_DI_NP_TO    = 20;
  localparam int B_DI_CPL_TO   = 21;
  localparam int B_DI_DAT_SBE  = 23;
  localparam int B_DI_DAT_DBE  = 24;
  localparam int B_DI_CTL_SBE  = 25;
  localparam int B_DI_CTL_DBE  = 26;
  localparam int B_DO_SBE      = 27;
  localparam int B_DO_DBE      = 28;
  localparam int B_DMA_PARITY  = 31;

  // ****************************************************************
  // Masks
  // ****************************************************************
  localparam logic [31:0] STS_IMPL_MASK = 32'h9fbe_fff7;
  localparam logic [31:0] STS_DMA_MASK  = 32'h9fb8_0000;
  localparam logic [31:0] STS_CORR_MASK = 32'h0a82_2a80;

endpackage : ieb_pkg

`default_nettype wire

/* File: rtl/ieb_flag_if.sv */
// Bundle between a sticky flag bank and the logic that sets and clears it.
// Assumes one clock shared by both ends.
`default_nettype none

interface ieb_flag_if #(
  parameter int W = 32
);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flags;

  modport bank (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface : ieb_flag_if

`default_nettype wire

/* File: rtl/ieb_sticky_bank.sv */
// Bank of sticky flags: set by hardware, cleared by writing ones.
// Assumes set and clear are qualified by the caller; set wins over clear.
`default_nettype none

module ieb_sticky_bank #(
  parameter int W = 32
) (
  // Clock, reset, enable
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  // Flag bundle
  ieb_flag_if.bank   fl
);

  logic [W-1:0] flags_q;

  // Hold, set or clear each flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else if (ce) begin
      flags_q <= (flags_q & ~fl.clr) | fl.set;
    end
  end

  assign fl.flags = flags_q;

endmodule : ieb_sticky_bank

`default_nettype wire

/* File: rtl/ieb_aer_fwd.sv */
// Forwards detected internal errors as corrected / uncorrected pulses.
// Assumes the event vector holds one-cycle detection pulses.
`default_nettype none

module ieb_aer_fwd (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Control and events
  input  wire logic        report_en,
  input  wire logic [31:0] ev,
  // Reporting pulses
  output logic             aer_corr_q,
  output logic             aer_uncorr_q
);

  // One pulse per cycle with a detection, only while enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aer_corr_q   <= 1'h0;
      aer_uncorr_q <= 1'h0;
    end else if (ce) begin
      aer_corr_q   <= report_en & (|(ev & ieb_pkg::STS_CORR_MASK));
      aer_uncorr_q <= report_en & (|(ev & ~ieb_pkg::STS_CORR_MASK));
    end
  end

endmodule : ieb_aer_fwd

`default_nettype wire

/* File: tb/ieb_bank_tb_top.sv */
// Self-checking bench for the internal error status bank.
// Assumes the bank package is compiled first; drives two ports, with and without DMA.
`default_nettype none

module ieb_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk;
  logic        rst_n;
  logic        rst_warm_n;
  logic        ce;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] ev;
  logic [31:0] rdata [2];
  logic        aer_c [2];
  logic        aer_u [2];
  logic        irq   [2];
  int          fails;
  int          comparisons;
  int          cycles;

  // ****************************************************************
  // Two ports: index 0 with DMA function, index 1 without
  // ****************************************************************
  for (genvar g = 0; g < 2; g++) begin : g_port
    ieb_bank #(.HAS_DMA(g == 0)) i_ieb_bank (
      .clk(clk), .rst_n(rst_n), .rst_warm_n(rst_warm_n), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(rdata[g]),
      .ingress_posted_timeout(ev[0]), .ingress_nonposted_timeout(ev[1]),
      .ingress_completion_timeout(ev[2]), .egress_posted_timeout(ev[4]),
      .egress_nonposted_timeout(ev[5]), .egress_completion_timeout(ev[6]),
      .ingress_data_single_err(ev[7]), .ingress_data_double_err(ev[8]),
      .ingress_ctl_single_err(ev[9]), .ingress_ctl_double_err(ev[10]),
      .egress_data_single_err(ev[11]), .egress_data_double_err(ev[12]),
      .egress_ctl_single_err(ev[13]), .egress_ctl_double_err(ev[14]),
      .datapath_parity_err(ev[15]), .replay_ctl_single_err(ev[17]),
      .replay_ctl_double_err(ev[18]), .dma_in_posted_timeout(ev[19]),
      .dma_in_nonposted_timeout(ev[20]), .dma_in_completion_timeout(ev[21]),
      .dma_in_data_single_err(ev[23]), .dma_in_data_double_err(ev[24]),
      .dma_in_ctl_single_err(ev[25]), .dma_in_ctl_double_err(ev[26]),
      .dma_out_single_err(ev[27]), .dma_out_double_err(ev[28]),
      .dma_datapath_parity_err(ev[31]),
      .aer_corr_q(aer_c[g]), .aer_uncorr_q(aer_u[g]), .irq(irq[g])
    );
  end

  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Cut a hung run short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write, then one idle cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(posedge clk);
  endtask : wr

  // One-cycle read; data checked in the following cycle on both ports
  task automatic rd(input logic [11:0] a, input logic [31:0] e0, input logic [31:0] e1);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk(rdata[0], e0);
    chk(rdata[1], e1);
    @(posedge clk);
  endtask : rd

  // One-cycle event pulse; reporting pulses checked the cycle after
  task automatic pulse(input logic [31:0] v, input logic c, input logic u);
    ev <= v;
    @(posedge clk);
    ev <= '0;
    #1;
    chk({31'h0, aer_c[0]}, {31'h0, c});
    chk({31'h0, aer_u[0]}, {31'h0, u});
    chk({31'h0, aer_c[1]}, {31'h0, c && ((v & ~ieb_pkg::STS_DMA_MASK) != 32'h0)});
    chk({31'h0, aer_u[1]}, {31'h0, u && ((v & ~ieb_pkg::STS_DMA_MASK) != 32'h0)});
    @(posedge clk);
  endtask : pulse

  task automatic done(input string n);
    $display("test %s done", n);
  endtask : done

  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [31:0] bitv;
    logic        corr;
    rst_n = 1'h0;
    rst_warm_n = 1'h1;
    ce = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = '0;
    reg_wdata = '0;
    ev = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    // Reset values and an unmapped place
    rd(ieb_pkg::OFF_CTRL, 32'h1, 32'h1);
    rd(ieb_pkg::OFF_STS_LOW, 32'h0, 32'h0);
    rd(12'h4a0, 32'h0, 32'h0);
    done("reset");
    // Every event sets its own flag, reports, and clears by writing one
    for (int i = 0; i < 32; i++) begin
      if (ieb_pkg::STS_IMPL_MASK[i]) begin
        bitv = 32'h1 << i;
        corr = ieb_pkg::STS_CORR_MASK[i];
        pulse(bitv, corr, !corr);
        rd(ieb_pkg::OFF_STS_LOW, bitv, bitv & ~ieb_pkg::STS_DMA_MASK);
        wr(ieb_pkg::OFF_STS_LOW, bitv);
        rd(ieb_pkg::OFF_STS_LOW, 32'h0, 32'h0);
      end
    end
    done("events");
    // Enable bit, reserved bits, write of zero
    wr(ieb_pkg::OFF_CTRL, 32'hffff_ffff);
    rd(ieb_pkg::OFF_CTRL, 32'h1, 32'h1);
    wr(ieb_pkg::OFF_CTRL, 32'h0);
    pulse(32'h0000_8000, 1'h0, 1'h0);
    rd(ieb_pkg::OFF_CTRL, 32'h0, 32'h0);
    wr(ieb_pkg::OFF_STS_LOW, 32'h0);
    rd(ieb_pkg::OFF_STS_LOW, 32'h0000_8000, 32'h0000_8000);
    wr(ieb_pkg::OFF_STS_LOW, 32'hffff_7fff);
    rd(ieb_pkg::OFF_STS_LOW, 32'h0000_8000, 32'h0000_8000);
    done("enable");
    // Warm reset keeps flags and enable; fundamental reset clears flags and sets enable back to one
    rst_warm_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_warm_n <= 1'h1;
    @(posedge clk);
    rd(ieb_pkg::OFF_STS_LOW, 32'h0000_8000, 32'h0000_8000);
    rd(ieb_pkg::OFF_CTRL, 32'h0, 32'h0);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(ieb_pkg::OFF_CTRL, 32'h1, 32'h1);
    rd(ieb_pkg::OFF_STS_LOW, 32'h0, 32'h0);
    done("resets");
    // Interrupt raised, masked, unmasked, cleared
    wr(ieb_pkg::OFF_IRQ_ENABLE, 32'hffff_ffff);
    rd(ieb_pkg::OFF_IRQ_ENABLE, ieb_pkg::STS_IMPL_MASK, ieb_pkg::STS_IMPL_MASK);
    pulse(32'h1, 1'h0, 1'h1);
    chk({30'h0, irq[1], irq[0]}, 32'h3);
    wr(ieb_pkg::OFF_IRQ_ENABLE, 32'h0);
    chk({30'h0, irq[1], irq[0]}, 32'h0);
    wr(ieb_pkg::OFF_IRQ_ENABLE, 32'h1);
    chk({30'h0, irq[1], irq[0]}, 32'h3);
    rd(ieb_pkg::OFF_IRQ_STATUS, 32'h1, 32'h1);
    wr(ieb_pkg::OFF_IRQ_CLEAR, 32'h1);
    chk({30'h0, irq[1], irq[0]}, 32'h0);
    rd(ieb_pkg::OFF_IRQ_CLEAR, 32'h0, 32'h0);
    rd(ieb_pkg::OFF_STS_LOW, 32'h1, 32'h1);
    done("interrupt");
    // Clock enable low freezes events and register writes
    ce <= 1'h0;
    pulse(32'h10, 1'h0, 1'h0);
    wr(ieb_pkg::OFF_CTRL, 32'h0);
    ce <= 1'h1;
    rd(ieb_pkg::OFF_STS_LOW, 32'h1, 32'h1);
    rd(ieb_pkg::OFF_CTRL, 32'h1, 32'h1);
    done("clock enable");
    results();
  end

endmodule : ieb_bank_tb_top

`default_nettype wire
